// ===== logic/trp_top.sv
// Torque reference path: source select, analog chain, filter, limit, flags
//
// Functional notes
// - selector 0 internal setpoint, 1 analog A
// - setpoint signed, plus/minus 3000 tenths percent
// - subtract calibrated zero drift per channel
// - subtract programmable offset after drift
// - dead band forces sample to zero
// - first-order filter, time constant milliseconds
// - ten volts maps to programmable torque
// - channel B has its own settings
// - corrected voltages readable as monitors
// - torque command filter in 0.01 units
// - clamp reference whose magnitude exceeds limit
// - one limit active, capped at 3000
// - limit from registers or analog B
// - forward limit register, default 3000
// - reverse limit register, default 3000
// - limit flag on output function 138
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/100ps
module trp_top #(
  parameter int SAMPLE_US = 50
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog samples in millivolts
  input wire logic signed [15:0] analog_in_a,
  input wire logic signed [15:0] analog_in_b,
  input wire logic analog_valid,
  // Drive state
  input wire logic motor_running,
  // Torque outputs
  output logic signed [15:0] torque_ref,
  output logic torque_ref_valid,
  output logic torque_limit_do,
  output logic irq
);
  import trp_pkg::*;

  // Divider needs 33 cycles between samples
  if (SAMPLE_US < 1 || SAMPLE_US > 1000) begin : g_bad
    $error("trp_top: SAMPLE_US out of range");
  end

  typedef struct packed {
    logic src_sel; // Torque source
    logic signed [15:0] setpoint; // Internal setpoint
    logic signed [15:0] a_off; // Channel A offset
    logic [15:0] a_tau; // Channel A filter time
    logic [15:0] a_dead; // Channel A dead band
    logic signed [15:0] a_drift; // Channel A drift
    logic signed [15:0] b_off; // Channel B offset
    logic [15:0] b_tau; // Channel B filter time
    logic [15:0] b_dead; // Channel B dead band
    logic signed [15:0] b_drift; // Channel B drift
    logic [15:0] fs_speed; // Speed at ten volts, stored only
    logic [15:0] fs_torque; // Torque at ten volts
    logic [15:0] tq_tau; // Torque filter time
    logic lim_sel; // Limit source
    logic [15:0] fwd_lim; // Forward limit
    logic [15:0] rev_lim; // Reverse limit
    logic [7:0] do_func; // Output function, as written
    logic [7:0] do_live; // Output function in force
    logic do_cap; // Function captured since reset
    logic [STS_W-1:0] status; // Sticky events
    logic [STS_W-1:0] mask; // Interrupt enables
    logic [STS_W-1:0] rd_capt; // Status seen by pending read
    logic [31:0] prdata; // Read data
    logic pready; // Access phase ready
    logic pslverr; // Unmapped address
    logic signed [15:0] ref_in; // Selected reference
    logic ref_vld; // Reference strobe
    logic signed [15:0] tq; // Limited torque
    logic tq_vld; // Torque strobe
    logic lim_hit; // Limit reached
    logic lim_do; // Output pin level
    logic irq; // Interrupt level
  } trp_top_s_t;

  trp_top_s_t r, n;

  // Streams between stages
  trp_stream_if cond_a ();
  trp_stream_if cond_b ();
  trp_stream_if filt_a ();
  trp_stream_if filt_b ();
  trp_stream_if tq_in ();
  trp_stream_if tq_out ();

  logic signed [15:0] mon_a; // Channel A voltage
  logic signed [15:0] mon_b; // Channel B voltage

  // Channel A conditioning and filter
  trp_ain_cond u_cond_a (
    .clk(pclk),
    .rstn(presetn),
    .raw(analog_in_a),
    .raw_valid(analog_valid),
    .drift(r.a_drift),
    .offset(r.a_off),
    .dead(r.a_dead),
    .monitor(mon_a),
    .dout(cond_a.src)
  );
  trp_lpf #(.TS_US(SAMPLE_US), .TAU_UNIT_US(AIN_TAU_UNIT_US)) u_lpf_a (
    .clk(pclk),
    .rstn(presetn),
    .tau(r.a_tau),
    .din(cond_a.snk),
    .dout(filt_a.src)
  );

  // Channel B, same chain with its own settings
  trp_ain_cond u_cond_b (
    .clk(pclk),
    .rstn(presetn),
    .raw(analog_in_b),
    .raw_valid(analog_valid),
    .drift(r.b_drift),
    .offset(r.b_off),
    .dead(r.b_dead),
    .monitor(mon_b),
    .dout(cond_b.src)
  );
  trp_lpf #(.TS_US(SAMPLE_US), .TAU_UNIT_US(AIN_TAU_UNIT_US)) u_lpf_b (
    .clk(pclk),
    .rstn(presetn),
    .tau(r.b_tau),
    .din(cond_b.snk),
    .dout(filt_b.src)
  );

  // Torque command filter, paced by channel A samples
  assign tq_in.data = r.ref_in;
  assign tq_in.valid = r.ref_vld;
  trp_lpf #(.TS_US(SAMPLE_US), .TAU_UNIT_US(TQ_TAU_UNIT_US)) u_lpf_tq (
    .clk(pclk),
    .rstn(presetn),
    .tau(r.tq_tau),
    .din(tq_in.snk),
    .dout(tq_out.src)
  );

  // Bus, registers, selection, limit and flags
  always_comb begin
    logic setup;
    logic wr;
    logic rd;
    logic signed [15:0] wv;
    logic signed [15:0] lim;
    logic signed [15:0] b_tq;
    logic [STS_W-1:0] ev;
    logic hit;
    setup = psel && !penable;
    wr = psel && penable && r.pready && pwrite;
    rd = psel && penable && r.pready && !pwrite;
    wv = $signed(pwdata[15:0]);
    lim = ZERO16;
    b_tq = ZERO16;
    ev = '0;
    hit = 1'b0;
    n = r;
    n.ref_vld = 1'b0;
    n.tq_vld = 1'b0;

    // Output function is taken once per reset, later writes wait
    if (!r.do_cap) begin
      n.do_live = r.do_func;
      n.do_cap = 1'b1;
    end

    // Setup phase: register answer so ready and data come from flops
    n.pready = setup;
    // Error answer stands only beside its ready, never sticky
    n.pslverr = 1'b0;
    if (setup) begin
      n.prdata = 32'h0000_0000;
      n.rd_capt = '0;
      unique case (paddr)
        OFS_TQ_SRC: n.prdata = {31'h0000_0000, r.src_sel};
        OFS_SETPOINT: n.prdata = {16'h0000, r.setpoint};
        OFS_A_OFF: n.prdata = {16'h0000, r.a_off};
        OFS_A_TAU: n.prdata = {16'h0000, r.a_tau};
        OFS_A_DEAD: n.prdata = {16'h0000, r.a_dead};
        OFS_A_DRIFT: n.prdata = {16'h0000, r.a_drift};
        OFS_B_OFF: n.prdata = {16'h0000, r.b_off};
        OFS_B_TAU: n.prdata = {16'h0000, r.b_tau};
        OFS_B_DEAD: n.prdata = {16'h0000, r.b_dead};
        OFS_B_DRIFT: n.prdata = {16'h0000, r.b_drift};
        OFS_FS_SPEED: n.prdata = {16'h0000, r.fs_speed};
        OFS_FS_TORQUE: n.prdata = {16'h0000, r.fs_torque};
        OFS_TQ_TAU: n.prdata = {16'h0000, r.tq_tau};
        OFS_LIM_SRC: n.prdata = {31'h0000_0000, r.lim_sel};
        OFS_FWD_LIM: n.prdata = {16'h0000, r.fwd_lim};
        OFS_REV_LIM: n.prdata = {16'h0000, r.rev_lim};
        OFS_DO_FUNC: n.prdata = {24'h00_0000, r.do_func};
        OFS_MON_A: n.prdata = {16'h0000, mon_a};
        OFS_MON_B: n.prdata = {16'h0000, mon_b};
        OFS_STATUS: begin
          n.prdata = {30'h0000_0000, r.status};
          n.rd_capt = pwrite ? '0 : r.status;
        end
        OFS_MASK: n.prdata = {30'h0000_0000, r.mask};
        OFS_TQ_OUT: n.prdata = {16'h0000, r.tq};
        default: n.pslverr = 1'b1;
      endcase
    end

    // Access phase write, values saturated into their ranges, bad function codes dropped
    if (wr && !r.pslverr) begin
      unique case (paddr)
        OFS_TQ_SRC, OFS_LIM_SRC: begin
          // Source changes only at standstill
          if (motor_running) begin
            ev[STS_REFUSED] = 1'b1;
          end else if (paddr == OFS_TQ_SRC) begin
            n.src_sel = pwdata[0];
          end else begin
            n.lim_sel = pwdata[0];
          end
        end
        OFS_SETPOINT: n.setpoint = trp_sat(32'(wv), TQ_MIN, TQ_MAX);
        OFS_A_OFF: n.a_off = trp_sat(32'(wv), OFF_MIN, OFF_MAX);
        OFS_A_TAU: n.a_tau = pwdata[15:0];
        OFS_A_DEAD: n.a_dead = trp_sat({16'h0000, pwdata[15:0]}, ZERO16, DEAD_MAX);
        OFS_A_DRIFT: n.a_drift = trp_sat(32'(wv), DRIFT_MIN, DRIFT_MAX);
        OFS_B_OFF: n.b_off = trp_sat(32'(wv), OFF_MIN, OFF_MAX);
        OFS_B_TAU: n.b_tau = pwdata[15:0];
        OFS_B_DEAD: n.b_dead = trp_sat({16'h0000, pwdata[15:0]}, ZERO16, DEAD_MAX);
        OFS_B_DRIFT: n.b_drift = trp_sat(32'(wv), DRIFT_MIN, DRIFT_MAX);
        OFS_FS_SPEED: n.fs_speed = trp_sat({16'h0000, pwdata[15:0]}, FSS_MIN, FSS_MAX);
        OFS_FS_TORQUE: n.fs_torque = trp_sat({16'h0000, pwdata[15:0]}, ZERO16, TQ_MAX);
        OFS_TQ_TAU: n.tq_tau = trp_sat({16'h0000, pwdata[15:0]}, TQTAU_MIN, TQTAU_MAX);
        OFS_FWD_LIM: n.fwd_lim = trp_sat({16'h0000, pwdata[15:0]}, ZERO16, TQ_MAX);
        OFS_REV_LIM: n.rev_lim = trp_sat({16'h0000, pwdata[15:0]}, ZERO16, TQ_MAX);
        OFS_DO_FUNC: begin
          // Out-of-range function codes are ignored
          if (pwdata[7:0] >= DO_FUNC_MIN && pwdata[7:0] <= DO_FUNC_MAX) begin
            n.do_func = pwdata[7:0];
          end
        end
        OFS_MASK: n.mask = pwdata[STS_W-1:0];
        default: n.mask = r.mask;
      endcase
    end

    // Reference select on each filtered channel A sample
    if (filt_a.valid) begin
      n.ref_vld = 1'b1;
      n.ref_in = r.src_sel ? trp_scale(filt_a.data, r.fs_torque) : r.setpoint;
    end

    // Active limit: one source, positive magnitude, capped
    b_tq = trp_scale(filt_b.data, r.fs_torque);
    if (r.lim_sel) begin
      lim = trp_sat((b_tq < 0) ? -32'(b_tq) : 32'(b_tq), ZERO16, TQ_MAX);
    end else if (tq_out.data < 0) begin
      lim = $signed(r.rev_lim);
    end else begin
      lim = $signed(r.fwd_lim);
    end

    // Clamp filtered command to the limit
    if (tq_out.valid) begin
      n.tq_vld = 1'b1;
      if (tq_out.data > lim) begin
        n.tq = lim;
      end else if (32'(tq_out.data) < -32'(lim)) begin
        n.tq = -lim;
      end else begin
        n.tq = tq_out.data;
      end
      hit = (tq_out.data >= lim) || (32'(tq_out.data) <= -32'(lim));
      n.lim_hit = hit;
      ev[STS_LIMIT] = hit && !r.lim_hit;
    end
    n.lim_do = n.lim_hit && (r.do_live == DO_FUNC_TLIMIT);

    // Read clears only what it returned; new events win
    n.status = (r.status & ~(rd ? r.rd_capt : '0)) | ev;
    n.irq = |(n.status & r.mask);
  end

  // State register with documented reset values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.a_tau <= RST_AIN_TAU;
      r.a_dead <= RST_AIN_DEAD;
      r.b_tau <= RST_AIN_TAU;
      r.b_dead <= RST_AIN_DEAD;
      r.fs_speed <= RST_FS_SPEED;
      r.fs_torque <= RST_FS_TORQUE;
      r.tq_tau <= RST_TQ_TAU;
      r.fwd_lim <= RST_LIMIT;
      r.rev_lim <= RST_LIMIT;
      r.do_func <= RST_DO_FUNC;
      r.do_live <= RST_DO_FUNC;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from flops
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign torque_ref = r.tq;
  assign torque_ref_valid = r.tq_vld;
  assign torque_limit_do = r.lim_do;
  assign irq = r.irq;
endmodule : trp_top

// ===== logic/trp_pkg.sv
// Shared constants, register map and helpers of the torque reference path
package trp_pkg;
  // Register byte addresses, one aligned word each
  localparam logic [7:0] OFS_TQ_SRC = 8'h00;
  localparam logic [7:0] OFS_SETPOINT = 8'h04;
  localparam logic [7:0] OFS_A_OFF = 8'h08;
  localparam logic [7:0] OFS_A_TAU = 8'h0C;
  localparam logic [7:0] OFS_A_DEAD = 8'h10;
  localparam logic [7:0] OFS_A_DRIFT = 8'h14;
  localparam logic [7:0] OFS_B_OFF = 8'h18;
  localparam logic [7:0] OFS_B_TAU = 8'h1C;
  localparam logic [7:0] OFS_B_DEAD = 8'h20;
  localparam logic [7:0] OFS_B_DRIFT = 8'h24;
  localparam logic [7:0] OFS_FS_SPEED = 8'h28;
  localparam logic [7:0] OFS_FS_TORQUE = 8'h2C;
  localparam logic [7:0] OFS_TQ_TAU = 8'h30;
  localparam logic [7:0] OFS_LIM_SRC = 8'h34;
  localparam logic [7:0] OFS_FWD_LIM = 8'h38;
  localparam logic [7:0] OFS_REV_LIM = 8'h3C;
  localparam logic [7:0] OFS_DO_FUNC = 8'h40;
  localparam logic [7:0] OFS_MON_A = 8'h44;
  localparam logic [7:0] OFS_MON_B = 8'h48;
  localparam logic [7:0] OFS_STATUS = 8'h4C;
  localparam logic [7:0] OFS_MASK = 8'h50;
  localparam logic [7:0] OFS_TQ_OUT = 8'h54;
  // Reset values
  localparam logic [15:0] RST_AIN_TAU = 16'h00C8;
  localparam logic [15:0] RST_AIN_DEAD = 16'h0014;
  localparam logic [15:0] RST_FS_SPEED = 16'h0BB8;
  localparam logic [15:0] RST_FS_TORQUE = 16'h03E8;
  localparam logic [15:0] RST_TQ_TAU = 16'h0032;
  localparam logic [15:0] RST_LIMIT = 16'h0BB8;
  localparam logic [7:0] RST_DO_FUNC = 8'h8A;
  // Legal ranges, writes are saturated into them; function codes outside are ignored
  localparam logic signed [15:0] TQ_MAX = 16'sh0BB8;
  localparam logic signed [15:0] TQ_MIN = 16'shF448;
  localparam logic signed [15:0] OFF_MAX = 16'sh1388;
  localparam logic signed [15:0] OFF_MIN = 16'shEC78;
  localparam logic signed [15:0] DRIFT_MAX = 16'sh01F4;
  localparam logic signed [15:0] DRIFT_MIN = 16'shFE0C;
  localparam logic signed [15:0] DEAD_MAX = 16'sh03E8;
  localparam logic signed [15:0] FSS_MIN = 16'sh03E8;
  localparam logic signed [15:0] FSS_MAX = 16'sh1194;
  localparam logic signed [15:0] TQTAU_MIN = 16'sh000A;
  localparam logic signed [15:0] TQTAU_MAX = 16'sh09C4;
  localparam logic signed [15:0] ZERO16 = 16'sh0000;
  localparam logic signed [15:0] S16_MAX = 16'sh7FFF;
  localparam logic signed [15:0] S16_MIN = 16'sh8000;
  localparam logic [7:0] DO_FUNC_MIN = 8'h80;
  localparam logic [7:0] DO_FUNC_MAX = 8'h8E;
  localparam logic [7:0] DO_FUNC_TLIMIT = 8'h8A;
  // Millivolts that map to full scale torque
  localparam logic signed [31:0] FULL_SCALE_MV = 32'sh0000_2710;
  // Filter time units in microseconds
  localparam int AIN_TAU_UNIT_US = 1000;
  localparam int TQ_TAU_UNIT_US = 10;
  // Status bit positions
  localparam int STS_LIMIT = 0;
  localparam int STS_REFUSED = 1;
  localparam int STS_W = 2;

  // Clamp a wide signed value into a 16-bit window
  function automatic logic signed [15:0] trp_sat(input logic signed [31:0] v,
                                                 input logic signed [15:0] lo,
                                                 input logic signed [15:0] hi);
    if (v < 32'(lo)) begin
      return lo;
    end else if (v > 32'(hi)) begin
      return hi;
    end
    return v[15:0];
  endfunction : trp_sat

  // Millivolts to tenths of a percent, full scale at ten volts
  function automatic logic signed [15:0] trp_scale(input logic signed [15:0] mv,
                                                   input logic [15:0] fs);
    logic signed [31:0] p;
    p = 32'(mv) * $signed({16'h0000, fs});
    return trp_sat(p / FULL_SCALE_MV, S16_MIN, S16_MAX);
  endfunction : trp_scale
endpackage : trp_pkg

// ===== logic/trp_stream_if.sv
// Sample stream between conditioner, filters and the top
`timescale 1ns/100ps
interface trp_stream_if;
  logic signed [15:0] data; // Sample value
  logic valid; // One-cycle strobe
  modport src(output data, output valid);
  modport snk(input data, input valid);
endinterface : trp_stream_if

// ===== logic/trp_ain_cond.sv
// Analog sample conditioning: drift, offset and dead zone
`timescale 1ns/100ps
module trp_ain_cond (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Raw sample in millivolts
  input wire logic signed [15:0] raw,
  input wire logic raw_valid,
  // Settings
  input wire logic signed [15:0] drift,
  input wire logic signed [15:0] offset,
  input wire logic [15:0] dead,
  // Outputs
  output logic signed [15:0] monitor,
  trp_stream_if.src dout
);
  import trp_pkg::*;

  typedef struct packed {
    logic signed [15:0] data; // Corrected sample
    logic signed [15:0] mon; // Drift-corrected voltage
    logic vld; // Output strobe
  } trp_cond_t;

  trp_cond_t r, n;

  // Drift, then offset, then dead zone
  always_comb begin
    logic signed [31:0] v1;
    logic signed [31:0] v2;
    logic [31:0] av;
    v1 = 32'sh0000_0000;
    v2 = 32'sh0000_0000;
    av = 32'h0000_0000;
    n = r;
    n.vld = raw_valid;
    if (raw_valid) begin
      v1 = 32'(raw) - 32'(drift);
      n.mon = trp_sat(v1, S16_MIN, S16_MAX);
      v2 = v1 - 32'(offset);
      av = (v2 < 0) ? 32'(-v2) : 32'(v2);
      // Inside the band counts as zero input
      if (av <= 32'(dead)) begin
        n.data = ZERO16;
      end else begin
        n.data = trp_sat(v2, S16_MIN, S16_MAX);
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign monitor = r.mon;
  assign dout.data = r.data;
  assign dout.valid = r.vld;
endmodule : trp_ain_cond

// ===== logic/trp_lpf.sv
// First-order low-pass filter, one serial division per sample
`timescale 1ns/100ps
module trp_lpf #(
  parameter int TS_US = 50,
  parameter int TAU_UNIT_US = 1000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Time constant in TAU_UNIT_US steps
  input wire logic [15:0] tau,
  // Streams
  trp_stream_if.snk din,
  trp_stream_if.src dout
);
  import trp_pkg::*;

  localparam logic [31:0] TS_W = 32'(TS_US);
  localparam logic [31:0] TAU_W = 32'(TAU_UNIT_US);

  // Refuse settings the 32-bit divider cannot hold
  if (TS_US < 1 || TS_US > 1000 || TAU_UNIT_US < 1 || TAU_UNIT_US > 1000) begin : g_bad
    $error("trp_lpf: unsupported sample period or time unit");
  end

  typedef enum logic [1:0] {TRP_LPF_IDLE = 2'b00, TRP_LPF_DIV = 2'b01} trp_lpf_st_t;

  typedef struct packed {
    trp_lpf_st_t st; // Divider state
    logic signed [15:0] y; // Filter output
    logic neg; // Error sign
    logic [31:0] num; // Dividend shifter
    logic [31:0] den; // Divisor
    logic [31:0] rem; // Partial remainder
    logic [31:0] quo; // Quotient
    logic [4:0] cnt; // Bit counter
    logic vld; // Output strobe
  } trp_lpf_s_t;

  trp_lpf_s_t r, n;

  // y += (x - y) * Ts / (tau + Ts); tau of zero passes x straight
  always_comb begin
    logic signed [16:0] e;
    logic [16:0] ae;
    logic [31:0] rs;
    logic signed [31:0] ys;
    e = 17'sh00000;
    ae = 17'h00000;
    rs = 32'h0000_0000;
    ys = 32'sh0000_0000;
    n = r;
    n.vld = 1'b0;
    unique case (r.st)
      TRP_LPF_IDLE: begin
        // Samples arriving mid-division are dropped
        if (din.valid) begin
          e = 17'(din.data) - 17'(r.y);
          ae = (e < 0) ? 17'(-e) : 17'(e);
          n.neg = (e < 0);
          n.num = 32'(ae) * TS_W;
          n.den = 32'(tau) * TAU_W + TS_W;
          n.rem = 32'h0000_0000;
          n.quo = 32'h0000_0000;
          n.cnt = 5'h00;
          n.st = TRP_LPF_DIV;
        end
      end
      TRP_LPF_DIV: begin
        rs = {r.rem[30:0], r.num[31]};
        n.num = {r.num[30:0], 1'b0};
        n.quo = {r.quo[30:0], (rs >= r.den)};
        n.rem = (rs >= r.den) ? rs - r.den : rs;
        n.cnt = r.cnt + 5'h01;
        // Last quotient bit: apply the step
        if (r.cnt == 5'h1F) begin
          ys = r.neg ? 32'(r.y) - $signed(n.quo) : 32'(r.y) + $signed(n.quo);
          n.y = trp_sat(ys, S16_MIN, S16_MAX);
          n.vld = 1'b1;
          n.st = TRP_LPF_IDLE;
        end
      end
      default: begin
        n.st = TRP_LPF_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign dout.data = r.y;
  assign dout.valid = r.vld;
endmodule : trp_lpf

// ===== dv/trp_chk.sv
// Port checker of the torque reference path
`timescale 1ns/100ps
module trp_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Torque side
  input wire logic analog_valid,
  input wire logic signed [15:0] torque_ref,
  input wire logic torque_ref_valid,
  input wire logic torque_limit_do
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Zero wait state answer
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready late");
  // No answer outside an access
  property p_stray; pready |-> psel && penable; endproperty
  a_stray: assert property (p_stray) else $error("stray pready");
  // Error only with answer, data zero
  property p_err; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
  a_err: assert property (p_err) else $error("bad error answer");
  // Output never beyond the hard cap
  property p_range;
    torque_ref_valid |-> torque_ref <= 16'sh0BB8 && torque_ref >= -16'sh0BB8;
  endproperty
  a_range: assert property (p_range) else $error("torque beyond cap");
  // Reference moves only with its strobe
  property p_hold; !$stable(torque_ref) |-> torque_ref_valid; endproperty
  a_hold: assert property (p_hold) else $error("torque moved alone");
  // Flag moves only with the reference
  property p_flag; !$stable(torque_limit_do) |-> torque_ref_valid; endproperty
  a_flag: assert property (p_flag) else $error("flag moved alone");
  // Strobe is a single pulse
  property p_pulse; torque_ref_valid |=> !torque_ref_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("strobe too long");
  // Each sample yields one reference in bounded time
  property p_lat; analog_valid |-> ##[40:120] torque_ref_valid; endproperty
  a_lat: assert property (p_lat) else $error("no reference");
  c_lim: cover property ($rose(torque_limit_do));
  c_err: cover property (pslverr);
  c_neg: cover property (torque_ref_valid && torque_ref < 0);
endmodule : trp_chk

bind trp_top trp_chk i_chk (.pclk, .presetn, .psel, .penable, .prdata, .pready,
  .pslverr, .analog_valid, .torque_ref, .torque_ref_valid, .torque_limit_do);

// ===== dv/trp_sampler.sv
// Analog front end model, one sample per request
`timescale 1ns/100ps
module trp_sampler (
  // Clock
  input wire logic clk,
  // Request
  input wire logic go,
  input wire logic signed [15:0] va,
  input wire logic signed [15:0] vb,
  // Sample lines
  output logic signed [15:0] ain_a = 16'h0000,
  output logic signed [15:0] ain_b = 16'h0000,
  output logic strobe = 1'b0
);
  // Lines toggle outside the strobe so stale data never passes
  always_ff @(posedge clk) begin
    strobe <= go;
    if (go) begin
      ain_a <= va;
      ain_b <= vb;
    end else begin
      ain_a <= ~ain_a;
      ain_b <= ~ain_b;
    end
  end
endmodule : trp_sampler

// ===== dv/trp_bench.sv
// Self-checking bench of the torque reference path
`timescale 1ns/100ps
module trp_bench;
  import trp_pkg::*;
  localparam int TS = 50;
  // Write order of the random setup
  localparam logic [7:0] CA[13] = '{OFS_TQ_SRC, OFS_SETPOINT, OFS_LIM_SRC, OFS_FWD_LIM,
    OFS_REV_LIM, OFS_A_DRIFT, OFS_A_OFF, OFS_A_DEAD, OFS_A_TAU, OFS_B_DRIFT, OFS_B_OFF,
    OFS_B_DEAD, OFS_B_TAU};
  localparam int LO[13] = '{0, -3000, 0, 0, 0, -500, -500, 0, 0, -500, -500, 0, 0};
  localparam int SP[13] = '{1, 6000, 1, 3000, 3000, 1000, 1000, 1000, 1, 1000, 1000, 1000, 1};
  // Reset image of offsets 0x00..0x40
  localparam logic [15:0] RV[17] = '{16'h0000, 16'h0000, 16'h0000, 16'h00C8, 16'h0014,
    16'h0000, 16'h0000, 16'h00C8, 16'h0014, 16'h0000, 16'h0BB8, 16'h03E8, 16'h0032,
    16'h0000, 16'h0BB8, 16'h0BB8, 16'h008A};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, avalid, motor_running, go;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic signed [15:0] ain_a, ain_b, va, vb, tref;
  logic tvalid, tlim, irq, e;
  int num_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int ya, yb, yt; // Model filter states
  int cfg[13]; // Model register image

  trp_sampler i_src (.clk(pclk), .go(go), .va(va), .vb(vb), .ain_a(ain_a), .ain_b(ain_b),
    .strobe(avalid));
  trp_top #(.SAMPLE_US(TS)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .analog_in_a(ain_a), .analog_in_b(ain_b),
    .analog_valid(avalid), .motor_running(motor_running), .torque_ref(tref),
    .torque_ref_valid(tvalid), .torque_limit_do(tlim), .irq(irq));

  initial begin
    forever #2.5 pclk = ~pclk;
  end

  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      $display("FAIL %0t timeout", $time);
      stop_test();
    end
  end

  task automatic stop_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the hang guard ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  function automatic int iabs(input int v);
    return v < 0 ? -v : v;
  endfunction : iabs

  function automatic int sat(input int v, input int lo, input int hi);
    return v < lo ? lo : (v > hi ? hi : v);
  endfunction : sat

  // One sample through the model and the design
  task automatic samp(input int ra, input int rb);
    int xa, xb, lim, n;
    va <= 16'(ra);
    vb <= 16'(rb);
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    xa = ra - cfg[5] - cfg[6];
    xb = rb - cfg[9] - cfg[10];
    xa = iabs(xa) <= cfg[7] ? 0 : xa;
    xb = iabs(xb) <= cfg[11] ? 0 : xb;
    ya += (xa - ya) * TS / (cfg[8] * 1000 + TS);
    yb += (xb - yb) * TS / (cfg[12] * 1000 + TS);
    xa = cfg[0] != 0 ? ya * 1000 / 10000 : cfg[1];
    yt += (xa - yt) * TS / (100 + TS);
    lim = cfg[2] != 0 ? sat(iabs(yb * 1000 / 10000), 0, 3000) : (yt >= 0 ? cfg[3] : cfg[4]);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (tvalid !== 1'b1 && n < 200);
    chk(32'(tref), 32'(iabs(yt) > lim ? (yt < 0 ? -lim : lim) : yt), "torque");
    chk(32'(tlim), 32'(iabs(yt) >= lim), "limit flag");
    apb(1'b0, OFS_MON_A, 32'h0);
    chk(r, {16'h0000, 16'(ra - cfg[5])}, "monitor a");
    apb(1'b0, OFS_MON_B, 32'h0);
    chk(r, {16'h0000, 16'(rb - cfg[9])}, "monitor b");
  endtask : samp

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    motor_running = 1'b0;
    go = 1'b0;
    va = 16'h0000;
    vb = 16'h0000;
    void'($urandom(32'hEEC4BD5E));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 17; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(r, {16'h0000, RV[i]}, "reset value");
    end
    apb(1'b0, 8'h58, 32'h0);
    chk({r[30:0], e}, 32'h1, "unmapped");
    apb(1'b1, OFS_TQ_TAU, 32'h5);
    apb(1'b0, OFS_TQ_TAU, 32'h0);
    chk(r, 32'hA, "filter floor");
    $display("test reset done");
    ya = 0;
    yb = 0;
    yt = 0;
    for (int k = 0; k < 16; k++) begin
      for (int j = 0; j < 13; j++) begin
        cfg[j] = int'($urandom_range(SP[j])) + LO[j];
        apb(1'b1, CA[j], {16'h0000, 16'(cfg[j])});
      end
      samp(int'($urandom_range(4000)) - 2000, int'($urandom_range(4000)) - 2000);
    end
    $display("test random done");
    motor_running <= 1'b1;
    apb(1'b1, OFS_MASK, 32'h2);
    apb(1'b1, OFS_TQ_SRC, 32'(1 - cfg[0]));
    apb(1'b0, OFS_TQ_SRC, 32'h0);
    chk(r, 32'(cfg[0]), "selector kept");
    chk(32'(irq), 32'h1, "irq raised");
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(r[1]), 32'h1, "refused bit");
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0, "irq cleared");
    motor_running <= 1'b0;
    $display("test refused done");
    stop_test();
  end
endmodule : trp_bench
